// ---- dac_cmd_pkg.sv ----
// Shared constants for the serial DAC command latch
package dac_cmd_pkg;
   localparam int WORD_BITS = 16;
   localparam int CODE_BITS = 12;
   localparam int CNT_BITS = 5;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam int BIT_IGNORE = 15;
   localparam int BIT_GAIN_N = 13;
   localparam int BIT_POWER = 12;
   localparam logic GAIN_N_RESET = 1'b0;
   localparam logic POWER_RESET = 1'b0;
   localparam logic [11:0] CODE_RESET = 12'h000;
   localparam int RES_DEFAULT = 12;
   localparam int PIN_COUNT = 5;
   // Pin order {supply_ok, power_down_n, load_strobe_n, sdi, cs_n}
   localparam logic [4:0] PIN_SYNC_RESET = 5'h0D;
   localparam int PIN_CS_N = 0;
   localparam int PIN_SDI = 1;
   localparam int PIN_STROBE_N = 2;
   localparam int PIN_PD_N = 3;
   localparam int PIN_SUPPLY_OK = 4;
endpackage

// ---- pin_sync.sv ----
// Two-flop synchronisers for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync needs WIDTH of at least 1");
   end

   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_r;
      logic sync_r;
      // Only the second stage is visible outside
      always_ff @(posedge clock) begin
         if (!rst_b) begin
            meta_r <= RESET_VAL[i];
            sync_r <= RESET_VAL[i];
         end else begin
            meta_r <= din[i];
            sync_r <= meta_r;
         end
      end
      assign dout[i] = sync_r;
   end
endmodule // pin_sync

// ---- cmd_receiver.sv ----
// Write-only serial command receiver, 16-bit frames
`timescale 1ns/1ps
module cmd_receiver (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic cs_n_s,
   input wire logic sck_s,
   input wire logic sdi_s,
   output logic word_valid,
   output logic [dac_cmd_pkg::WORD_BITS-1:0] word
);
   import dac_cmd_pkg::*;

   logic sck_prev_r;
   logic cs_prev_r;
   logic [CNT_BITS-1:0] cnt_r;
   logic [WORD_BITS-1:0] shift_r;
   logic sck_rise;
   logic cs_rise;
   logic shift_en;

   assign sck_rise = sck_s && !sck_prev_r;
   assign cs_rise = cs_n_s && !cs_prev_r;
   // Edges past the sixteenth are dropped until the frame ends
   assign shift_en = !cs_n_s && sck_rise && (cnt_r != FRAME_BITS);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sck_prev_r <= 1'b0;
         cs_prev_r <= 1'b1;
      end else begin
         sck_prev_r <= sck_s;
         cs_prev_r <= cs_n_s;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b || cs_n_s) begin
         cnt_r <= '0;
      end else if (shift_en) begin
         cnt_r <= cnt_r + CNT_BITS'(1);
      end
   end

   // MSB first; frame data stays put while chip select is high
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         shift_r <= '0;
      end else if (shift_en) begin
         shift_r <= {shift_r[WORD_BITS-2:0], sdi_s};
      end
   end

   // A short frame never raises the strobe, so nothing downstream moves
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         word_valid <= 1'b0;
      end else begin
         word_valid <= cs_rise && (cnt_r == FRAME_BITS);
      end
   end

   assign word = shift_r;

   a_extra_ignored: assert property (@(posedge clock) disable iff (!rst_b)
      (!cs_n_s && sck_rise && cnt_r == FRAME_BITS) |=> $stable(shift_r))
      else $error("clock edge after sixteen bits changed the shift register");
   a_short_abort: assert property (@(posedge clock) disable iff (!rst_b)
      (cs_rise && cnt_r != FRAME_BITS) |=> !word_valid)
      else $error("short frame produced a command");
   a_frame_done: assert property (@(posedge clock) disable iff (!rst_b)
      (cs_rise && cnt_r == FRAME_BITS) |=> (word_valid && word == $past(shift_r)))
      else $error("complete frame not delivered");
   a_cs_high_idle: assert property (@(posedge clock) disable iff (!rst_b)
      cs_n_s |=> ($stable(shift_r) && cnt_r == '0))
      else $error("bits taken while chip select high");
   a_rise_sample: assert property (@(posedge clock) disable iff (!rst_b)
      shift_en |=> (shift_r[0] == $past(sdi_s) && cnt_r == $past(cnt_r) + CNT_BITS'(1)))
      else $error("data not sampled on clock rise");
endmodule // cmd_receiver

// ---- dac_command_latch.sv ----
// Top: serial command latch, double buffer and shutdown control
`timescale 1ns/1ps
module dac_command_latch #(
   parameter int RESOLUTION = dac_cmd_pkg::RES_DEFAULT
) (
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic CS_N,
   input wire logic SCK,
   input wire logic SDI,
   input wire logic OUTPUT_LOAD_STROBE_N,
   input wire logic POWER_DOWN_CONTROL_N,
   input wire logic SUPPLY_OK,
   output logic [RESOLUTION-1:0] CODE_OUT,
   output logic GAIN_DOUBLE,
   output logic OUTPUT_ENABLE,
   output logic LOAD_CONNECT,
   output logic MONITOR_ENABLE,
   output logic REFERENCE_ENABLE
);
   import dac_cmd_pkg::*;

   if (!(RESOLUTION == 8 || RESOLUTION == 10 || RESOLUTION == 12)) begin : g_bad_res
      $error("RESOLUTION must be 8, 10 or 12");
   end

   logic [PIN_COUNT-1:0] pins_s;
   logic cs_n_s;
   logic sdi_s;
   logic sck_s;
   logic strobe_n_s;
   logic pd_n_s;
   logic supply_ok_s;
   logic word_valid;
   logic [WORD_BITS-1:0] word;
   logic supply_fail;
   logic hold_rst;
   logic accept;
   logic load_now;
   logic active_nxt;
   logic in_gain_n_r;
   logic in_power_r;
   logic [CODE_BITS-1:0] in_code_r;
   logic in_valid_r;
   logic out_gain_n_r;
   logic out_power_r;
   logic [CODE_BITS-1:0] out_code_r;
   logic out_loaded_r;
   logic out_gain_n_nxt;
   logic out_power_nxt;
   logic [CODE_BITS-1:0] out_code_nxt;

   // SCK has its own synchroniser so its edges line up with SDI
   pin_sync #(
      .WIDTH(PIN_COUNT),
      .RESET_VAL(PIN_SYNC_RESET)
   ) u_pin_sync (
      .clock(CLOCK),
      .rst_b(RST_B),
      .din({SUPPLY_OK, POWER_DOWN_CONTROL_N, OUTPUT_LOAD_STROBE_N, SDI, CS_N}),
      .dout(pins_s)
   );

   pin_sync #(
      .WIDTH(1),
      .RESET_VAL(1'b0)
   ) u_sck_sync (
      .clock(CLOCK),
      .rst_b(RST_B),
      .din(SCK),
      .dout(sck_s)
   );

   assign cs_n_s = pins_s[PIN_CS_N];
   assign sdi_s = pins_s[PIN_SDI];
   assign strobe_n_s = pins_s[PIN_STROBE_N];
   assign pd_n_s = pins_s[PIN_PD_N];
   assign supply_ok_s = pins_s[PIN_SUPPLY_OK];

   // Receiver runs regardless of shutdown; it has no serial output
   cmd_receiver u_rx (
      .clock(CLOCK),
      .rst_b(RST_B),
      .cs_n_s(cs_n_s),
      .sck_s(sck_s),
      .sdi_s(sdi_s),
      .word_valid(word_valid),
      .word(word)
   );

   // Monitor is ignored while the pin holds the part down
   assign supply_fail = pd_n_s && !supply_ok_s;
   assign hold_rst = !RST_B || supply_fail;
   assign accept = word_valid && !word[BIT_IGNORE];
   assign load_now = !strobe_n_s && (accept || in_valid_r);

   // Input register
   always_ff @(posedge CLOCK) begin
      if (hold_rst) begin
         in_gain_n_r <= GAIN_N_RESET;
         in_power_r <= POWER_RESET;
         in_code_r <= CODE_RESET;
      end else if (accept) begin
         in_gain_n_r <= word[BIT_GAIN_N];
         in_power_r <= word[BIT_POWER];
         in_code_r <= word[CODE_BITS-1:0];
      end
   end

   // Cleared by reset so a fresh command is needed after supply recovery
   always_ff @(posedge CLOCK) begin
      if (hold_rst) begin
         in_valid_r <= 1'b0;
      end else if (accept) begin
         in_valid_r <= 1'b1;
      end
   end

   // New word bypasses the input register so a tied-low strobe costs no cycle
   always_comb begin
      if (accept) begin
         out_gain_n_nxt = word[BIT_GAIN_N];
         out_power_nxt = word[BIT_POWER];
         out_code_nxt = word[CODE_BITS-1:0];
      end else begin
         out_gain_n_nxt = in_gain_n_r;
         out_power_nxt = in_power_r;
         out_code_nxt = in_code_r;
      end
   end

   // Output register: all fields move on the same edge
   always_ff @(posedge CLOCK) begin
      if (hold_rst) begin
         out_gain_n_r <= GAIN_N_RESET;
         out_power_r <= POWER_RESET;
         out_code_r <= CODE_RESET;
      end else if (load_now) begin
         out_gain_n_r <= out_gain_n_nxt;
         out_power_r <= out_power_nxt;
         out_code_r <= out_code_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (hold_rst) begin
         out_loaded_r <= 1'b0;
      end else if (load_now) begin
         out_loaded_r <= 1'b1;
      end
   end

   // Active only when loaded, power bit set and pin high
   assign active_nxt = out_loaded_r && out_power_r && pd_n_s;

   always_ff @(posedge CLOCK) begin
      if (hold_rst) begin
         OUTPUT_ENABLE <= 1'b0;
         LOAD_CONNECT <= 1'b1;
      end else begin
         OUTPUT_ENABLE <= active_nxt;
         LOAD_CONNECT <= !active_nxt;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (hold_rst) begin
         GAIN_DOUBLE <= !GAIN_N_RESET;
      end else begin
         GAIN_DOUBLE <= !out_gain_n_r;
      end
   end

   // Left-justified code, unsigned binary; the analogue side scales by
   // reference times gain over two to the resolution
   always_ff @(posedge CLOCK) begin
      if (hold_rst) begin
         CODE_OUT <= '0;
      end else begin
         CODE_OUT <= out_code_r[CODE_BITS-1 -: RESOLUTION];
      end
   end

   // Pin shutdown switches the monitor off to save current
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         MONITOR_ENABLE <= 1'b1;
      end else begin
         MONITOR_ENABLE <= pd_n_s;
      end
   end

   // Reference is never touched by shutdown
   always_ff @(posedge CLOCK) begin
      if (!RST_B) begin
         REFERENCE_ENABLE <= 1'b1;
      end else begin
         REFERENCE_ENABLE <= 1'b1;
      end
   end

   a_supply_reset: assert property (@(posedge CLOCK) disable iff (!RST_B)
      supply_fail |=> (GAIN_DOUBLE && !OUTPUT_ENABLE && LOAD_CONNECT && !in_valid_r))
      else $error("supply fail did not hold reset");
   a_msb_discard: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (word_valid && word[BIT_IGNORE]) |=> ($stable(in_code_r) && $stable(in_power_r)))
      else $error("command with bit 15 set was taken");
   a_latch_word: assert property (@(posedge CLOCK) disable iff (hold_rst)
      accept |=> (in_code_r == $past(word[CODE_BITS-1:0]) && in_valid_r
         && in_gain_n_r == $past(word[BIT_GAIN_N])))
      else $error("valid command not latched");
   a_load_copy: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (!strobe_n_s && in_valid_r && !word_valid) |=> (out_code_r == in_code_r
         && out_power_r == in_power_r && out_gain_n_r == in_gain_n_r))
      else $error("strobe low did not copy input register");
   a_strobe_hold: assert property (@(posedge CLOCK) disable iff (hold_rst)
      strobe_n_s |=> ($stable(out_code_r) && $stable(out_gain_n_r) && $stable(out_power_r)))
      else $error("output register moved with strobe high");
   a_tied_low: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (accept && !strobe_n_s) |=> out_code_r == $past(word[CODE_BITS-1:0]))
      else $error("tied-low strobe did not update at once");
   a_pin_down: assert property (@(posedge CLOCK) disable iff (hold_rst)
      !pd_n_s |=> (!OUTPUT_ENABLE && LOAD_CONNECT && !MONITOR_ENABLE && REFERENCE_ENABLE))
      else $error("pin shutdown not applied");
   a_soft_down: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (!out_power_r && pd_n_s) |=> (!OUTPUT_ENABLE && MONITOR_ENABLE))
      else $error("software shutdown not applied");
   a_powerup_hiz: assert property (@(posedge CLOCK) disable iff (hold_rst)
      !out_loaded_r |=> (!OUTPUT_ENABLE && LOAD_CONNECT))
      else $error("output active before first load");
   a_wake_up: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (out_loaded_r && out_power_r && pd_n_s) |=> (OUTPUT_ENABLE && !LOAD_CONNECT))
      else $error("did not leave shutdown");
   a_gain_map: assert property (@(posedge CLOCK) disable iff (hold_rst)
      1'b1 |=> GAIN_DOUBLE == !$past(out_gain_n_r))
      else $error("gain bit sense wrong");

   // Buffer and port checks
   a_enable_pair: assert property (@(posedge CLOCK) disable iff (!RST_B)
      OUTPUT_ENABLE == !LOAD_CONNECT)
      else $error("output enable and load switch disagree");
   a_monitor_on: assert property (@(posedge CLOCK) disable iff (!RST_B)
      pd_n_s |=> MONITOR_ENABLE)
      else $error("monitor off without pin shutdown");
   a_pin_keeps: assert property (@(posedge CLOCK) disable iff (!RST_B)
      (!pd_n_s && !supply_ok_s && in_valid_r) |=> in_valid_r)
      else $error("supply monitor acted during pin shutdown");
   a_ref_kept: assert property (@(posedge CLOCK) disable iff (!RST_B)
      (!pd_n_s || !out_power_r) |=> REFERENCE_ENABLE)
      else $error("reference switched off in shutdown");
   a_reset_state: assert property (@(posedge CLOCK)
      hold_rst |=> (CODE_OUT == '0 && GAIN_DOUBLE && !OUTPUT_ENABLE && LOAD_CONNECT
         && !out_loaded_r && in_gain_n_r == GAIN_N_RESET))
      else $error("reset state not applied");
   a_gain_default: assert property (@(posedge CLOCK) disable iff (hold_rst)
      !out_loaded_r |=> GAIN_DOUBLE)
      else $error("gain not double before first load");
   a_in_hold: assert property (@(posedge CLOCK) disable iff (hold_rst)
      !accept |=> ($stable(in_code_r) && $stable(in_gain_n_r) && $stable(in_power_r)))
      else $error("input register moved without a command");
   a_valid_stays: assert property (@(posedge CLOCK) disable iff (hold_rst)
      in_valid_r |=> in_valid_r)
      else $error("valid flag lost without reset");
   a_no_early_load: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (!in_valid_r && !accept) |=> ($stable(out_loaded_r) && $stable(out_code_r)))
      else $error("output loaded before a valid command");
   a_loaded_stays: assert property (@(posedge CLOCK) disable iff (hold_rst)
      out_loaded_r |=> out_loaded_r)
      else $error("loaded flag lost without reset");
   a_out_whole: assert property (@(posedge CLOCK) disable iff (hold_rst)
      load_now |=> (out_code_r == $past(out_code_nxt) && out_gain_n_r == $past(out_gain_n_nxt)
         && out_power_r == $past(out_power_nxt)))
      else $error("output register fields moved apart");
   a_direct_out: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (accept && !strobe_n_s) |=> ##1 (CODE_OUT == $past(word[CODE_BITS-1 -: RESOLUTION], 2)
         && GAIN_DOUBLE == !$past(word[BIT_GAIN_N], 2)))
      else $error("tied-low strobe did not reach the outputs");
   a_power_out: assert property (@(posedge CLOCK) disable iff (hold_rst)
      (accept && !strobe_n_s) ##1 pd_n_s |=> OUTPUT_ENABLE == $past(word[BIT_POWER], 2))
      else $error("latched power bit not applied");
endmodule // dac_command_latch

// ---- spi_master_model.sv ----
// Behavioural serial master driving chip select, serial clock and data
`timescale 1ns/1ps
module spi_master_model (
   input wire logic clock,
   output logic cs_n,
   output logic sck,
   output logic sdi
);
   // 40 ns half period gives the 80 ns link clock
   localparam int HALF = 5;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   task automatic wait_half();
      repeat (HALF) @(posedge clock);
   endtask
   // Clock idles at the mode level between frames; bits past the word toggle
   task automatic send(input logic [15:0] word, input int nbits, input logic idle);
      int i;
      sck <= idle;
      wait_half();
      cs_n <= 1'b0;
      wait_half();
      for (i = 0; i < nbits; i++) begin
         sck <= 1'b0;
         sdi <= (i < 16) ? word[15 - i] : i[0];
         wait_half();
         sck <= 1'b1;
         wait_half();
      end
      sck <= idle;
      wait_half();
      cs_n <= 1'b1;
      // Released data line must not keep showing the last bit
      sdi <= ~sdi;
      wait_half();
   endtask
endmodule // spi_master_model

// ---- dac_command_latch_tb.sv ----
// Self-checking bench for the serial DAC command latch
`timescale 1ns/1ps
module dac_command_latch_tb;
   import dac_cmd_pkg::*;
   logic clock;
   logic rst_b;
   logic cs_n;
   logic sck;
   logic sdi;
   logic strobe_n;
   logic pd_n;
   logic supply_ok;
   logic [11:0] code_out;
   logic gain_double;
   logic out_en;
   logic load_conn;
   logic mon_en;
   logic ref_en;
   int n_errors = 0;
   int samples_checked = 0;

   spi_master_model master_u (
      .clock(clock),
      .cs_n(cs_n),
      .sck(sck),
      .sdi(sdi)
   );

   dac_command_latch #(.RESOLUTION(12)) dut_u (
      .CLOCK(clock),
      .RST_B(rst_b),
      .CS_N(cs_n),
      .SCK(sck),
      .SDI(sdi),
      .OUTPUT_LOAD_STROBE_N(strobe_n),
      .POWER_DOWN_CONTROL_N(pd_n),
      .SUPPLY_OK(supply_ok),
      .CODE_OUT(code_out),
      .GAIN_DOUBLE(gain_double),
      .OUTPUT_ENABLE(out_en),
      .LOAD_CONNECT(load_conn),
      .MONITOR_ENABLE(mon_en),
      .REFERENCE_ENABLE(ref_en)
   );

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Code, gain and enables compared as one word so a partial update shows
   task automatic expect_out(input logic [11:0] code, input logic gd, input logic oe);
      check({1'b0, code_out, gain_double, out_en, load_conn}, {1'b0, code, gd, oe, ~oe});
   endtask

   task automatic settle();
      repeat (10) @(posedge clock);
   endtask

   task automatic frame(input logic [15:0] w, input int n, input logic idle);
      master_u.send(w, n, idle);
      settle();
   endtask

   task automatic t_reset();
      expect_out(CODE_RESET, 1'b1, 1'b0);
      check({15'h0000, mon_en}, 16'h0001);
      check({15'h0000, ref_en}, 16'h0001);
   endtask

   task automatic t_double_buffer();
      strobe_n <= 1'b0;
      settle();
      expect_out(12'h000, 1'b1, 1'b0);
      strobe_n <= 1'b1;
      frame(16'h3ABC, 16, 1'b0);
      expect_out(12'h000, 1'b1, 1'b0);
      strobe_n <= 1'b0;
      settle();
      expect_out(12'hABC, 1'b0, 1'b1);
   endtask

   // Strobe stays low so any wrongly accepted frame reaches the outputs
   task automatic t_refused();
      frame(16'h3123, 15, 1'b0);
      expect_out(12'hABC, 1'b0, 1'b1);
      frame(16'h9123, 16, 1'b0);
      expect_out(12'hABC, 1'b0, 1'b1);
      frame(16'h4555, 16, 1'b0);
      expect_out(12'h555, 1'b1, 1'b0);
      check({15'h0000, mon_en}, 16'h0001);
   endtask

   task automatic t_long_mode3();
      frame(16'h3123, 20, 1'b1);
      expect_out(12'h123, 1'b0, 1'b1);
   endtask

   task automatic t_pin_shutdown();
      pd_n <= 1'b0;
      settle();
      expect_out(12'h123, 1'b0, 1'b0);
      check({15'h0000, mon_en}, 16'h0000);
      check({15'h0000, ref_en}, 16'h0001);
      frame(16'h3FFF, 16, 1'b0);
      expect_out(12'hFFF, 1'b0, 1'b0);
      // Supply dip while the pin holds shutdown must not reset anything
      supply_ok <= 1'b0;
      settle();
      expect_out(12'hFFF, 1'b0, 1'b0);
      supply_ok <= 1'b1;
      settle();
      pd_n <= 1'b1;
      settle();
      expect_out(12'hFFF, 1'b0, 1'b1);
   endtask

   task automatic t_supply();
      supply_ok <= 1'b0;
      settle();
      expect_out(CODE_RESET, 1'b1, 1'b0);
      check({15'h0000, mon_en}, 16'h0001);
      supply_ok <= 1'b1;
      settle();
      expect_out(12'h000, 1'b1, 1'b0);
      frame(16'h3800, 16, 1'b0);
      expect_out(12'h800, 1'b0, 1'b1);
   endtask

   // Mid-run reset must bring back double gain and shutdown
   task automatic t_hard_reset();
      rst_b <= 1'b0;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      repeat (5) @(posedge clock);
      expect_out(CODE_RESET, 1'b1, 1'b0);
      frame(16'h1246, 16, 1'b0);
      expect_out(12'h246, 1'b1, 1'b1);
   endtask

   // Whole run is about 1650 cycles
   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      finish_test();
   end

   initial begin
      rst_b = 1'b0;
      strobe_n = 1'b1;
      pd_n = 1'b1;
      supply_ok = 1'b1;
      repeat (8) @(posedge clock);
      rst_b <= 1'b1;
      repeat (5) @(posedge clock);
      t_reset();
      t_double_buffer();
      t_refused();
      t_long_mode3();
      t_pin_shutdown();
      t_supply();
      t_hard_reset();
      finish_test();
   end
endmodule // dac_command_latch_tb
